// ===== src/modbus_scaling_exception_responder.sv
// Purpose: judge a decoded request, scale writes, and send the reply
// Assumes: frame parser and parameter checker on the same clock
// Notes: reply bytes leave on a valid/ready byte stream
//
// Behaviour
// - scale is ten to the decimal places, capped at four places
// - stored write integer is value times scale
// - good reply echoes function code and address
// - rejected reply sets function code top bit
// - exactly one exception byte follows that code
// - code 01H: function unsupported or device faulted
// - code 02H: data address not permitted
// - code 03H: data field structurally not allowed
// - code 04H: write value out of range
// - code 05H: password check value mismatch
// - code 06H: bad frame length or CRC
// - code 07H: write to read-only parameter
// - code 08H: write locked while running
// - code 09H: access other than a password write while password lock active
`timescale 1ns/10ps
module modbus_scaling_exception_responder
    import modbus_resp_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_req_valid,
    input wire logic [7:0] i_slave_addr,
    input wire logic [7:0] i_func,
    input wire logic [15:0] i_reg_addr,
    input wire logic [15:0] i_data,
    input wire logic [2:0] i_decimals,
    input wire logic i_is_write,
    input wire logic i_frame_ok,
    input wire logic i_func_supported,
    input wire logic i_faulted,
    input wire logic i_addr_ok,
    input wire logic i_value_ok,
    input wire logic i_range_ok,
    input wire logic i_read_only,
    input wire logic i_run_locked,
    input wire logic i_running,
    input wire logic i_pw_location,
    input wire logic [15:0] i_user_password_setting,
    input wire logic i_sys_locked,
    input wire logic i_tx_ready,
    output logic o_req_ready,
    output logic o_tx_valid,
    output logic [7:0] o_tx_data,
    output logic o_tx_last,
    output logic o_store_valid,
    output logic [15:0] o_store_raw,
    output logic [15:0] o_store_scale,
    output logic [15:0] o_store_whole,
    output logic [15:0] o_store_frac,
    output logic o_exc_valid,
    output logic [7:0] o_exc_code
);

    // ********************************************************
    // request judgement
    // ********************************************************
    logic take;
    logic exc_hit;
    logic [7:0] exc_sel;
    logic [15:0] scale;

    assign take = i_req_valid && o_req_ready;

    always_comb begin
        exc_hit = 1'b1;
        exc_sel = EXC_ILLEGAL_FUNC;
        if (!i_frame_ok) begin
            exc_sel = EXC_BAD_FRAME;
        end else if (!i_func_supported || i_faulted) begin
            exc_sel = EXC_ILLEGAL_FUNC;
        end else if (i_sys_locked && !(i_is_write && i_pw_location)) begin
            exc_sel = EXC_SYS_LOCKED;
        end else if (!i_addr_ok) begin
            exc_sel = EXC_ILLEGAL_ADDR;
        end else if (!i_value_ok) begin
            exc_sel = EXC_ILLEGAL_VALUE;
        end else if (i_is_write && i_read_only) begin
            exc_sel = EXC_READ_ONLY;
        end else if (i_is_write && i_run_locked && i_running) begin
            exc_sel = EXC_RUN_LOCKED;
        end else if (i_is_write && i_pw_location &&
                     i_data != i_user_password_setting) begin
            exc_sel = EXC_BAD_PASSWORD;
        end else if (i_is_write && !i_pw_location && !i_range_ok) begin
            exc_sel = EXC_OP_FAILURE;
        end else begin
            exc_hit = 1'b0;
        end
    end

    // scale is ten to the power of the decimal places, capped at four places
    always_comb begin
        scale = SCALE_UNITY;
        for (int d = 0; d < MAX_DECIMALS; d++) begin
            if (d < int'(i_decimals)) begin
                scale = 16'(scale * SCALE_BASE);
            end
        end
    end

    // ********************************************************
    // scaled store output
    // ********************************************************
    logic store_valid_r, store_valid_nxt;
    logic [15:0] store_raw_r, store_raw_nxt;
    logic [15:0] store_scale_r, store_scale_nxt;
    logic [15:0] store_whole_r, store_whole_nxt;
    logic [15:0] store_frac_r, store_frac_nxt;

    always_comb begin
        store_valid_nxt = 1'b0;
        store_raw_nxt = store_raw_r;
        store_scale_nxt = store_scale_r;
        store_whole_nxt = store_whole_r;
        store_frac_nxt = store_frac_r;
        if (take && i_is_write && !exc_hit && !i_pw_location) begin
            // integer on the wire is engineering value times scale
            store_valid_nxt = 1'b1;
            store_raw_nxt = i_data;
            store_scale_nxt = scale;
            store_whole_nxt = i_data / scale;
            store_frac_nxt = i_data % scale;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            store_valid_r <= 1'b0;
            store_raw_r <= 16'h0000;
            store_scale_r <= SCALE_UNITY;
            store_whole_r <= 16'h0000;
            store_frac_r <= 16'h0000;
        end else begin
            store_valid_r <= store_valid_nxt;
            store_raw_r <= store_raw_nxt;
            store_scale_r <= store_scale_nxt;
            store_whole_r <= store_whole_nxt;
            store_frac_r <= store_frac_nxt;
        end
    end

    // ********************************************************
    // reply sequencer
    // ********************************************************
    reply_state_t state_r, state_nxt;
    logic [7:0] frame_r [0:5];
    logic [7:0] frame_nxt [0:5];
    logic [3:0] len_r, len_nxt;
    logic [3:0] idx_r, idx_nxt;
    logic [15:0] crc_r, crc_nxt;
    logic [15:0] crc_step;
    logic exc_valid_r, exc_valid_nxt;
    logic [7:0] exc_code_r, exc_code_nxt;
    logic [7:0] cur_byte;
    logic in_crc;
    logic sent;

    assign in_crc = (idx_r >= len_r - 4'd2);
    assign sent = o_tx_valid && i_tx_ready;

    always_comb begin
        if (!in_crc) begin
            cur_byte = frame_r[idx_r[2:0]];
        end else if (idx_r == len_r - 4'd2) begin
            cur_byte = crc_r[7:0];
        end else begin
            cur_byte = crc_r[15:8];
        end
    end

    crc16_byte #(
        .POLY(CRC_POLY)
    ) u_crc (
        .i_crc(crc_r),
        .i_byte(cur_byte),
        .o_crc(crc_step)
    );

    always_comb begin
        state_nxt = state_r;
        frame_nxt = frame_r;
        len_nxt = len_r;
        idx_nxt = idx_r;
        crc_nxt = crc_r;
        exc_valid_nxt = 1'b0;
        exc_code_nxt = exc_code_r;
        case (state_r)
            ST_IDLE: begin
                if (take) begin
                    frame_nxt[0] = i_slave_addr;
                    idx_nxt = 4'd0;
                    crc_nxt = CRC_INIT;
                    state_nxt = ST_SEND;
                    if (exc_hit) begin
                        frame_nxt[1] = i_func | FUNC_EXC_FLAG;
                        frame_nxt[2] = exc_sel;
                        len_nxt = EXC_FRAME_LEN;
                        exc_valid_nxt = 1'b1;
                        exc_code_nxt = exc_sel;
                    end else begin
                        frame_nxt[1] = i_func;
                        frame_nxt[2] = i_reg_addr[15:8];
                        frame_nxt[3] = i_reg_addr[7:0];
                        frame_nxt[4] = i_data[15:8];
                        frame_nxt[5] = i_data[7:0];
                        len_nxt = NORMAL_FRAME_LEN;
                    end
                end
            end
            ST_SEND: begin
                if (sent) begin
                    if (!in_crc) begin
                        crc_nxt = crc_step;
                    end
                    if (idx_r == len_r - 4'd1) begin
                        state_nxt = ST_IDLE;
                    end else begin
                        idx_nxt = idx_r + 4'd1;
                    end
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_r <= ST_IDLE;
            for (int i = 0; i < 6; i++) begin
                frame_r[i] <= 8'h00;
            end
            len_r <= NORMAL_FRAME_LEN;
            idx_r <= 4'd0;
            crc_r <= CRC_INIT;
            exc_valid_r <= 1'b0;
            exc_code_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            frame_r <= frame_nxt;
            len_r <= len_nxt;
            idx_r <= idx_nxt;
            crc_r <= crc_nxt;
            exc_valid_r <= exc_valid_nxt;
            exc_code_r <= exc_code_nxt;
        end
    end

    // ********************************************************
    // outputs
    // ********************************************************
    assign o_req_ready = (state_r == ST_IDLE);
    assign o_tx_valid = (state_r == ST_SEND);
    assign o_tx_data = cur_byte;
    assign o_tx_last = (state_r == ST_SEND) && (idx_r == len_r - 4'd1);
    assign o_store_valid = store_valid_r;
    assign o_store_raw = store_raw_r;
    assign o_store_scale = store_scale_r;
    assign o_store_whole = store_whole_r;
    assign o_store_frac = store_frac_r;
    assign o_exc_valid = exc_valid_r;
    assign o_exc_code = exc_code_r;

endmodule : modbus_scaling_exception_responder

// ===== inc/modbus_resp_pkg.sv
// Purpose: shared constants for the slave reply and scaling block
// Assumes: Modbus RTU framing, 8-bit reply bytes
// Notes: exception codes and CRC settings live here only
package modbus_resp_pkg;

    // ********************************************************
    // exception codes
    // ********************************************************
    localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
    localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
    localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
    localparam logic [7:0] EXC_OP_FAILURE = 8'h04;
    localparam logic [7:0] EXC_BAD_PASSWORD = 8'h05;
    localparam logic [7:0] EXC_BAD_FRAME = 8'h06;
    localparam logic [7:0] EXC_READ_ONLY = 8'h07;
    localparam logic [7:0] EXC_RUN_LOCKED = 8'h08;
    localparam logic [7:0] EXC_SYS_LOCKED = 8'h09;

    // ********************************************************
    // framing
    // ********************************************************
    localparam logic [7:0] FUNC_EXC_FLAG = 8'h80;
    localparam logic [3:0] EXC_FRAME_LEN = 4'h5;
    localparam logic [3:0] NORMAL_FRAME_LEN = 4'h8;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'hA001;

    // ********************************************************
    // fieldbus scale
    // ********************************************************
    localparam logic [15:0] SCALE_BASE = 16'h000A;
    localparam logic [15:0] SCALE_UNITY = 16'h0001;
    localparam int MAX_DECIMALS = 4;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SEND
    } reply_state_t;

endpackage : modbus_resp_pkg

// ===== src/crc16_byte.sv
// Purpose: one byte step of the Modbus CRC-16 (reflected)
// Assumes: purely combinational, used once per reply byte ahead of the two CRC bytes
// Notes: polynomial is a parameter, default the Modbus value
`timescale 1ns/10ps
module crc16_byte
    import modbus_resp_pkg::*;
#(
    parameter logic [15:0] POLY = CRC_POLY
) (
    input wire logic [15:0] i_crc,
    input wire logic [7:0] i_byte,
    output logic [15:0] o_crc
);

    always_comb begin
        logic [15:0] c;
        c = i_crc ^ {8'h00, i_byte};
        for (int b = 0; b < 8; b++) begin
            if (c[0]) begin
                c = (c >> 1) ^ POLY;
            end else begin
                c = c >> 1;
            end
        end
        o_crc = c;
    end

endmodule : crc16_byte

// ===== test/modbus_resp_chk.sv
// Purpose: port checks for the reply and scaling block
// Assumes: one clock, asynchronous active-high reset
// Notes: reply byte index is counted in helper logic
`timescale 1ns/10ps
module modbus_resp_chk (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_req_valid,
    input wire logic i_tx_ready,
    input wire logic o_req_ready,
    input wire logic o_tx_valid,
    input wire logic [7:0] o_tx_data,
    input wire logic o_tx_last,
    input wire logic o_store_valid,
    input wire logic [15:0] o_store_raw,
    input wire logic [15:0] o_store_scale,
    input wire logic [15:0] o_store_whole,
    input wire logic [15:0] o_store_frac,
    input wire logic o_exc_valid,
    input wire logic [7:0] o_exc_code
);
    logic [2:0] idx_r, idx_nxt;
    logic exc_r, exc_nxt;
    always_comb begin
        idx_nxt = idx_r;
        if (o_tx_valid && i_tx_ready) begin
            idx_nxt = o_tx_last ? 3'h0 : idx_r + 3'h1;
        end
        exc_nxt = o_exc_valid | (exc_r & !(i_req_valid && o_req_ready));
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            idx_r <= 3'h0;
            exc_r <= 1'b0;
        end else begin
            idx_r <= idx_nxt;
            exc_r <= exc_nxt;
        end
    end
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    sequence s_take;
        i_req_valid && o_req_ready;
    endsequence
    sequence s_stall;
        o_tx_valid && !i_tx_ready;
    endsequence
    a_take_reply: assert property (s_take |=> o_tx_valid && !o_req_ready)
        else $error("reply did not start after a taken request");
    a_busy_refuse: assert property (o_tx_valid |-> !o_req_ready)
        else $error("request accepted while replying");
    a_stall_hold: assert property (s_stall |=> o_tx_valid && $stable(o_tx_data))
        else $error("reply byte changed while stalled");
    a_exc_flag_bit: assert property (o_tx_valid && exc_r && idx_r == 3'h1
        |-> o_tx_data[7])
        else $error("exception function code lacks top bit");
    a_exc_code_byte: assert property (o_tx_valid && exc_r && idx_r == 3'h2
        |-> o_tx_data == o_exc_code)
        else $error("exception byte differs from reported code");
    a_last_position: assert property (o_tx_valid
        |-> o_tx_last == (idx_r == (exc_r ? 3'h4 : 3'h7)))
        else $error("reply length wrong");
    a_exc_one_pulse: assert property (o_exc_valid |=> !o_exc_valid)
        else $error("exception flag held too long");
    a_scale_pow_ten: assert property (o_store_valid |-> o_store_scale inside
        {16'h0001, 16'h000A, 16'h0064, 16'h03E8, 16'h2710})
        else $error("scale not a power of ten");
    a_store_split: assert property (o_store_valid |-> o_store_frac
        < o_store_scale && {16'h0000, o_store_whole} * o_store_scale
        + o_store_frac == {16'h0000, o_store_raw})
        else $error("stored value split wrong");
endmodule : modbus_resp_chk
bind modbus_scaling_exception_responder modbus_resp_chk u_chk (.*);

// ===== test/byte_sink_model.sv
// Purpose: master-side sink of reply bytes
// Assumes: ready stalls on a fixed pattern
// Notes: accepted bytes gather in q
`timescale 1ns/10ps
module byte_sink_model (
    input wire logic i_clk,
    input wire logic i_valid,
    input wire logic [7:0] i_data,
    output logic o_ready
);
    logic [7:0] q[$];
    logic [2:0] cnt_r = 3'h0;
    initial o_ready = 1'b0;
    always @(posedge i_clk) begin
        if (i_valid && o_ready) q.push_back(i_data);
        cnt_r <= cnt_r + 3'h1;
        o_ready <= cnt_r != 3'h2 && cnt_r != 3'h5 && cnt_r != 3'h6;
    end
endmodule : byte_sink_model

// ===== test/modbus_scaling_exception_responder_tb.sv
// Purpose: self-checking bench for the reply and scaling block
// Assumes: stall pattern from the sink model
// Notes: reference reply built from flags and a bench CRC
`timescale 1ns/10ps
module modbus_scaling_exception_responder_tb import modbus_resp_pkg::*;;
    logic i_clk, i_rst, i_req_valid, i_is_write, i_frame_ok;
    logic i_func_supported, i_faulted, i_addr_ok, i_value_ok, i_range_ok;
    logic i_read_only, i_run_locked, i_running, i_pw_location, i_sys_locked;
    logic i_tx_ready, o_req_ready, o_tx_valid, o_tx_last;
    logic o_store_valid, o_exc_valid;
    logic [7:0] i_slave_addr, i_func, o_tx_data, o_exc_code;
    logic [15:0] i_reg_addr, i_data, i_user_password_setting, o_store_raw;
    logic [15:0] o_store_scale, o_store_whole, o_store_frac;
    logic [2:0] i_decimals;
    logic [31:0] rng = 32'hF20D957C;
    logic [31:0] r2;
    logic [7:0] exp_q[$];
    int n_fail = 0;
    int n_compared = 0;
    modbus_scaling_exception_responder DUT (.*);
    byte_sink_model sink (.i_clk(i_clk), .i_valid(o_tx_valid),
        .i_data(o_tx_data), .o_ready(i_tx_ready));
    function automatic logic [31:0] xs(logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    function automatic logic [15:0] crc(logic [7:0] b[$]);
        logic [15:0] c;
        c = CRC_INIT;
        foreach (b[i]) begin
            c ^= {8'h00, b[i]};
            for (int k = 0; k < 8; k++) c = c[0] ? c >> 1 ^ CRC_POLY : c >> 1;
        end
        return c;
    endfunction : crc
    function automatic logic [7:0] exp_code();
        logic w;
        w = i_is_write;
        if (!i_frame_ok) return EXC_BAD_FRAME;
        if (!i_func_supported || i_faulted) return EXC_ILLEGAL_FUNC;
        if (i_sys_locked && !(w && i_pw_location)) begin
            return EXC_SYS_LOCKED;
        end
        if (!i_addr_ok) return EXC_ILLEGAL_ADDR;
        if (!i_value_ok) return EXC_ILLEGAL_VALUE;
        if (w && i_read_only) return EXC_READ_ONLY;
        if (w && i_run_locked && i_running) return EXC_RUN_LOCKED;
        if (w && i_pw_location && i_data != i_user_password_setting) begin
            return EXC_BAD_PASSWORD;
        end
        if (w && !i_pw_location && !i_range_ok) begin
            return EXC_OP_FAILURE;
        end
        return 8'h00;
    endfunction : exp_code
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize
    // master scales the engineering value into d
    task automatic drive(logic [12:0] bad, logic [7:0] a, f,
        logic [15:0] ra, d, logic [2:0] dec);
        @(posedge i_clk);
        {i_req_valid, i_slave_addr, i_func, i_reg_addr} <= {1'b1, a, f, ra};
        {i_data, i_decimals, i_is_write} <= {d, dec, bad[11]};
        {i_frame_ok, i_func_supported, i_faulted} <= {~bad[1:0], bad[2]};
        {i_sys_locked, i_addr_ok, i_value_ok} <= {bad[3], ~bad[5:4]};
        {i_read_only, i_run_locked, i_running} <= bad[8:6];
        {i_pw_location, i_range_ok} <= {bad[9], !bad[10]};
        i_user_password_setting <= bad[12] ? d ^ 16'h0001 : d;
    endtask : drive
    task automatic run();
        logic [7:0] code;
        logic [15:0] sc, c;
        logic st;
        int n;
        @(posedge i_clk);
        i_req_valid <= 1'b0;
        code = exp_code();
        sc = 16'(10 ** (i_decimals > 4 ? 4 : i_decimals));
        st = code == 8'h00 && i_is_write && !i_pw_location;
        if (code != 8'h00) exp_q = {i_slave_addr, i_func | 8'h80, code};
        else exp_q = {i_slave_addr, i_func, i_reg_addr[15:8],
            i_reg_addr[7:0], i_data[15:8], i_data[7:0]};
        c = crc(exp_q);
        exp_q.push_back(c[7:0]);
        exp_q.push_back(c[15:8]);
        #1;
        check("exc_valid", o_exc_valid, code != 8'h00);
        if (code != 8'h00) check("exc_code", o_exc_code, code);
        check("store_valid", o_store_valid, st);
        if (st) begin
            check("raw", o_store_raw, i_data);
            check("scale", o_store_scale, sc);
            check("whole", o_store_whole, i_data / sc);
            check("frac", o_store_frac, i_data % sc);
        end
        for (n = 0; n < 100 && sink.q.size() < exp_q.size(); n++) begin
            @(posedge i_clk);
        end
        if (sink.q.size() < exp_q.size()) begin
            $display("[FAIL] reply_bytes expected %0d seen %0d",
                exp_q.size(), sink.q.size());
            n_fail++;
            summarize();
        end
        foreach (exp_q[i]) check("byte", sink.q[i], exp_q[i]);
        sink.q.delete();
        #1;
        check("req_ready", o_req_ready, 1'b1);
    endtask : run
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    initial begin
        {i_req_valid, i_slave_addr, i_func, i_reg_addr, i_data} = '0;
        {i_decimals, i_is_write, i_frame_ok, i_func_supported} = '0;
        {i_faulted, i_addr_ok, i_value_ok, i_range_ok, i_read_only} = '0;
        {i_run_locked, i_running, i_pw_location, i_sys_locked} = '0;
        i_user_password_setting = '0;
        i_rst = 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        drive(13'h0C00, 8'h01, 8'h06, 16'h0001, 16'h0003, 3'h0);
        run();
        // 5.0 times scale 10 gives 0032 on the wire
        drive(13'h0800, 8'h01, 8'h06, 16'h0114, 16'h0032, 3'h1);
        run();
        check("eng_value", o_store_whole, 16'h0005);
        drive(13'h1A08, 8'h02, 8'h06, 16'h0010, 16'h1234, 3'h0);
        run();
        drive(13'h0A08, 8'h02, 8'h06, 16'h0010, 16'h1234, 3'h0);
        run();
        drive(13'h08C0, 8'h03, 8'h06, 16'h0003, 16'h2710, 3'h2);
        run();
        for (int i = 0; i < 300; i++) begin
            rng = xs(rng);
            r2 = xs(rng);
            drive(rng[12:0] & rng[25:13] & r2[12:0] | {r2[20], 11'h000},
                rng[31:24], r2[7:0], {rng[7:0], r2[15:8]}, r2[31:16],
                r2[18:16]);
            run();
        end
        drive(13'h0001, 8'h05, 8'h03, 16'h0000, 16'h0001, 3'h0);
        @(posedge i_clk);
        i_req_valid <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b1;
        #1;
        check("rst_tx_valid", o_tx_valid, 1'b0);
        check("rst_scale", o_store_scale, 16'h0001);
        check("rst_req_ready", o_req_ready, 1'b1);
        check("rst_exc_valid", o_exc_valid, 1'b0);
        check("rst_exc_code", o_exc_code, 16'h0000);
        sink.q.delete();
        @(posedge i_clk);
        i_rst <= 1'b0;
        drive(13'h0020, 8'h07, 8'h10, 16'h2000, 16'h0002, 3'h2);
        run();
        summarize();
    end
endmodule : modbus_scaling_exception_responder_tb
